// *** src/tmr2_top.sv ***
// Behaviour
// - overflow sets overflow flag unless a uart clock select is set; software clears it.
// - with trigger enable, trigger-pin falling edge that captures/reloads sets trigger flag.
// - rx clock select 1 picks this overflow, 0 the other timer's, for uart.
// - tx clock select 1 picks this overflow, 0 the other timer's, for uart.
// - trigger pin ignored unless enabled and both uart clock selects are zero.
// - run control 0 halts counting, 1 lets the count advance.
// - timer mode steps the count once every 2 system clocks.
// - counter mode steps the count on each count-pin falling edge.
// - reload mode reloads on overflow and on enabled trigger-pin falling edges.
// - capture mode with trigger enable copies the count on trigger-pin falls.
// - any uart clock select forces auto-reload on overflow, ignoring capture select.
// - 16-bit reload/capture value lives in low and high byte registers.
// - running count is two writable byte registers resetting to zero.
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "tmr2_defines.svh"

module tmr2_top
  import tmr2_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TMR2_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_input_pin,
  input wire logic trigger_input_pin,
  input wire logic other_timer_ovf,
  output logic uart_rx_clock,
  output logic uart_tx_clock,
  output logic timer_req,
  output logic irq
);
  // control and data registers
  tmr2_byte_t ctrl_q, ctrl_d;
  tmr2_word_t rcap_q, rcap_d;
  tmr2_word_t cnt_q, cnt_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic ovf_q, ovf_d;
  tmr2_bus_e bus_q, bus_d;
  logic [31:0] rdat_q, rdat_d;

  // decoded control fields
  logic run, ct_mode, cap_mode, trig_en, rx_sel, tx_sel, uart_clk;
  assign run = ctrl_q[`TMR2_CTRL_RUN];
  assign ct_mode = ctrl_q[`TMR2_CTRL_CT];
  assign cap_mode = ctrl_q[`TMR2_CTRL_CAP];
  assign trig_en = ctrl_q[`TMR2_CTRL_TRIGEN];
  assign rx_sel = ctrl_q[`TMR2_CTRL_RXSEL];
  assign tx_sel = ctrl_q[`TMR2_CTRL_TXSEL];
  assign uart_clk = rx_sel | tx_sel;

  // pin edges, synchronised first
  logic cnt_fall, trig_fall, tick;

  tmr2_edge_sync u_cnt_sync (
    .clk(clk),
    .rst(rst),
    .pin(count_input_pin),
    .fall(cnt_fall)
  );

  tmr2_edge_sync u_trig_sync (
    .clk(clk),
    .rst(rst),
    .pin(trigger_input_pin),
    .fall(trig_fall)
  );

  tmr2_prescale u_pre (
    .clk(clk),
    .rst(rst),
    .run(run && !ct_mode),
    .tick(tick)
  );

  // count step, overflow and trigger qualification
  logic step, ovf, trig_act, do_reload, do_capture;
  assign step = run && (ct_mode ? cnt_fall : tick);
  assign ovf = step && (cnt_q == 16'hffff);
  assign trig_act = trig_en && !uart_clk && trig_fall;
  // uart clock use forces reload regardless of capture select
  assign do_reload = ovf && (uart_clk || !cap_mode) ||
                     trig_act && !cap_mode;
  assign do_capture = trig_act && cap_mode;

  // bus access decode
  logic acc, wr, rd_hit;
  logic [7:0] idx;
  assign acc = wb_cyc_i && wb_stb_i && (bus_q == TMR2_BUS_IDLE);
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[`TMR2_ADDR_W-1:2];

  // register next state; hardware sets beat software clears on flags
  always_comb begin
    ctrl_d = ctrl_q;
    rcap_d = rcap_q;
    cnt_d = cnt_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr) begin
      if (idx == `TMR2_IDX_CTRL) begin
        ctrl_d = wb_dat_i[7:0];
      end else if (idx == `TMR2_IDX_RCAP_LO) begin
        rcap_d[7:0] = wb_dat_i[7:0];
      end else if (idx == `TMR2_IDX_RCAP_HI) begin
        rcap_d[15:8] = wb_dat_i[7:0];
      end else if (idx == `TMR2_IDX_CNT_LO) begin
        cnt_d[7:0] = wb_dat_i[7:0];
      end else if (idx == `TMR2_IDX_CNT_HI) begin
        cnt_d[15:8] = wb_dat_i[7:0];
      end else if (idx == `TMR2_IDX_IRQ_STAT) begin
        stat_d = stat_q & ~wb_dat_i[1:0];
      end else if (idx == `TMR2_IDX_IRQ_MASK) begin
        mask_d = wb_dat_i[1:0];
      end
    end
    // counter: reload/capture win over a software byte write in the same cycle
    if (do_reload) begin
      cnt_d = rcap_q;
    end else if (step) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (do_capture) begin
      rcap_d = cnt_q;
    end
    if (ovf && !uart_clk) begin
      ctrl_d[`TMR2_CTRL_OVF] = 1'b1;
      stat_d[`TMR2_IRQ_OVF] = 1'b1;
    end
    if (trig_act) begin
      ctrl_d[`TMR2_CTRL_TRIG] = 1'b1;
      stat_d[`TMR2_IRQ_TRIG] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `TMR2_RST_BYTE;
      rcap_q <= `TMR2_RST_WORD;
      cnt_q <= `TMR2_RST_WORD;
      stat_q <= `TMR2_RST_IRQ;
      mask_q <= `TMR2_RST_IRQ;
    end else begin
      ctrl_q <= ctrl_d;
      rcap_q <= rcap_d;
      cnt_q <= cnt_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // overflow pulse registered for the uart clock outputs
  always_comb begin
    ovf_d = ovf;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // uart bit clock source mux; other timer pulse taken as-is (same clock)
  assign uart_rx_clock = rx_sel ? ovf_q : other_timer_ovf;
  assign uart_tx_clock = tx_sel ? ovf_q : other_timer_ovf;

  // cpu-side request and masked interrupt
  assign timer_req = ctrl_q[`TMR2_CTRL_OVF] | ctrl_q[`TMR2_CTRL_TRIG];
  assign irq = |(stat_q & mask_q);

  // read mux; unmapped addresses read zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (idx == `TMR2_IDX_CTRL) begin
      rdat_d[7:0] = ctrl_q;
    end else if (idx == `TMR2_IDX_RCAP_LO) begin
      rdat_d[7:0] = rcap_q[7:0];
    end else if (idx == `TMR2_IDX_RCAP_HI) begin
      rdat_d[7:0] = rcap_q[15:8];
    end else if (idx == `TMR2_IDX_CNT_LO) begin
      rdat_d[7:0] = cnt_q[7:0];
    end else if (idx == `TMR2_IDX_CNT_HI) begin
      rdat_d[7:0] = cnt_q[15:8];
    end else if (idx == `TMR2_IDX_IRQ_STAT) begin
      rdat_d[1:0] = stat_q;
    end else if (idx == `TMR2_IDX_IRQ_MASK) begin
      rdat_d[1:0] = mask_q;
    end
    if (!acc) begin
      rdat_d = rdat_q;
    end
  end

  // one-cycle ack after the request, dropped the cycle after
  always_comb begin
    case (bus_q)
      TMR2_BUS_IDLE: begin
        bus_d = acc ? TMR2_BUS_ACK : TMR2_BUS_IDLE;
      end
      TMR2_BUS_ACK: begin
        bus_d = TMR2_BUS_IDLE;
      end
      default: begin
        bus_d = TMR2_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_q <= TMR2_BUS_IDLE;
      rdat_q <= 32'h0000_0000;
    end else begin
      bus_q <= bus_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = (bus_q == TMR2_BUS_ACK);
  assign wb_dat_o = rdat_q;

  // checks; the sticky ones skip bus writes since only software may clear
  property p_ovf_sets_flag;
    @(posedge clk) disable iff (rst)
    (ovf && !uart_clk) |=> ctrl_q[`TMR2_CTRL_OVF];
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag)
    else $error("overflow did not set flag");

  property p_no_flag_uart;
    @(posedge clk) disable iff (rst)
    (uart_clk && !ctrl_q[`TMR2_CTRL_OVF] && !wr) |=> !ctrl_q[`TMR2_CTRL_OVF];
  endproperty
  a_no_flag_uart: assert property (p_no_flag_uart)
    else $error("overflow flag set in uart clock mode");

  property p_flag_sticky;
    @(posedge clk) disable iff (rst)
    (ctrl_q[`TMR2_CTRL_OVF] && !wr) |=> ctrl_q[`TMR2_CTRL_OVF];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag dropped without a write");

  property p_stat_set;
    @(posedge clk) disable iff (rst)
    (ovf && !uart_clk) |=> stat_q[`TMR2_IRQ_OVF];
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("overflow status bit not set");

  property p_trig_flag;
    @(posedge clk) disable iff (rst)
    trig_act |=> ctrl_q[`TMR2_CTRL_TRIG];
  endproperty
  a_trig_flag: assert property (p_trig_flag)
    else $error("trigger edge flag not set");

  property p_trig_sticky;
    @(posedge clk) disable iff (rst)
    (ctrl_q[`TMR2_CTRL_TRIG] && !wr) |=> ctrl_q[`TMR2_CTRL_TRIG];
  endproperty
  a_trig_sticky: assert property (p_trig_sticky)
    else $error("trigger edge flag dropped without a write");

  property p_trig_ignored;
    @(posedge clk) disable iff (rst)
    (trig_fall && (!trig_en || uart_clk) && !wr) |=>
      (rcap_q == $past(rcap_q)) && !$rose(ctrl_q[`TMR2_CTRL_TRIG]);
  endproperty
  a_trig_ignored: assert property (p_trig_ignored)
    else $error("trigger acted while disabled");

  property p_halt;
    @(posedge clk) disable iff (rst)
    (!run && !wr && !do_reload) |=> cnt_q == $past(cnt_q);
  endproperty
  a_halt: assert property (p_halt)
    else $error("count moved while halted");

  property p_timer_rate;
    @(posedge clk) disable iff (rst)
    (run && !ct_mode && step) |=> !step;
  endproperty
  a_timer_rate: assert property (p_timer_rate)
    else $error("timer stepped faster than every 2 clocks");

  property p_timer_steady;
    @(posedge clk) disable iff (rst)
    (run && !ct_mode && !step && !wr) |=> step;
  endproperty
  a_timer_steady: assert property (p_timer_steady)
    else $error("timer stepped slower than every 2 clocks");

  property p_counter_step;
    @(posedge clk) disable iff (rst)
    (run && ct_mode && cnt_fall && !do_reload && !wr) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_counter_step: assert property (p_counter_step)
    else $error("count pin edge did not step the count");

  property p_reload;
    @(posedge clk) disable iff (rst)
    (ovf && !cap_mode) |=> cnt_q == $past(rcap_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("no reload on overflow");

  property p_capture;
    @(posedge clk) disable iff (rst)
    do_capture |=> rcap_q == $past(cnt_q);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture missed");

  property p_forced_reload;
    @(posedge clk) disable iff (rst)
    (ovf && uart_clk) |=> cnt_q == $past(rcap_q);
  endproperty
  a_forced_reload: assert property (p_forced_reload)
    else $error("uart mode did not reload");

  property p_rx_mux;
    @(posedge clk) disable iff (rst)
    (rx_sel && ovf) |=> uart_rx_clock;
  endproperty
  a_rx_mux: assert property (p_rx_mux)
    else $error("rx clock missed own overflow");

  property p_tx_mux;
    @(posedge clk) disable iff (rst)
    (tx_sel && ovf && !wr) |=> uart_tx_clock;
  endproperty
  a_tx_mux: assert property (p_tx_mux)
    else $error("tx clock missed own overflow");

  property p_req;
    @(posedge clk) disable iff (rst)
    (ovf && !uart_clk) |=> timer_req;
  endproperty
  a_req: assert property (p_req)
    else $error("request not raised");
endmodule

// *** src/tmr2_defines.svh ***
`ifndef TMR2_DEFINES_SVH
`define TMR2_DEFINES_SVH

// register word indices (printed offsets are not all multiples of four: byte address is index * 4)
`define TMR2_IDX_CTRL 8'hc8
`define TMR2_IDX_RCAP_LO 8'hca
`define TMR2_IDX_RCAP_HI 8'hcb
`define TMR2_IDX_CNT_LO 8'hcc
`define TMR2_IDX_CNT_HI 8'hcd
`define TMR2_IDX_IRQ_STAT 8'hd8
`define TMR2_IDX_IRQ_MASK 8'hd9
`define TMR2_ADDR_W 10

// control register fields
`define TMR2_CTRL_OVF 7
`define TMR2_CTRL_TRIG 6
`define TMR2_CTRL_RXSEL 5
`define TMR2_CTRL_TXSEL 4
`define TMR2_CTRL_TRIGEN 3
`define TMR2_CTRL_RUN 2
`define TMR2_CTRL_CT 1
`define TMR2_CTRL_CAP 0

// irq status/mask fields
`define TMR2_IRQ_OVF 0
`define TMR2_IRQ_TRIG 1

// reset values
`define TMR2_RST_BYTE 8'h00
`define TMR2_RST_WORD 16'h0000
`define TMR2_RST_IRQ 2'h0

// timer mode prescale: one step every 2 system clocks
`define TMR2_TICK_DIV 2

`endif

// *** src/tmr2_pkg.sv ***
package tmr2_pkg;
  typedef logic [7:0] tmr2_byte_t;
  typedef logic [15:0] tmr2_word_t;
  // bus slave states, gray along idle -> ack
  typedef enum logic [1:0] {
    TMR2_BUS_IDLE = 2'b00,
    TMR2_BUS_ACK = 2'b01
  } tmr2_bus_e;
endpackage

// *** src/tmr2_edge_sync.sv ***
`include "tmr2_defines.svh"

// two-flop synchroniser plus falling edge detect for a pin
module tmr2_edge_sync
  import tmr2_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic fall
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  // pins idle high, so reset to one to avoid a false edge
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // edge looks only at the second and third flops
  assign fall = prev_q & ~sync_q;
endmodule

// *** src/tmr2_prescale.sv ***
`include "tmr2_defines.svh"

// divider giving a one-cycle tick every TICK_DIV clocks
module tmr2_prescale
  import tmr2_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  localparam int unsigned DIV = `TMR2_TICK_DIV;
  logic [1:0] cnt_q, cnt_d;

  // held at zero while stopped so the first tick is a full period away
  always_comb begin
    if (!run) begin
      cnt_d = 2'h0;
    end else if (cnt_q == 2'(DIV - 1)) begin
      cnt_d = 2'h0;
    end else begin
      cnt_d = cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = run && (cnt_q == 2'(DIV - 1));
endmodule

// *** verif/tmr2_pin_model.sv ***
// far-side pins: count pin, trigger pin, other timer overflow
module tmr2_pin_model (
  input wire logic clk,
  output logic count_pin,
  output logic trig_pin,
  output logic other_ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle high, so only a real fall makes an edge
  initial begin
    count_pin = 1'h1;
    trig_pin = 1'h1;
    other_ovf = 1'h0;
  end
  // low phase held well past the two-flop synchroniser
  task automatic fall(input bit trig);
    @(posedge clk);
    if (trig) trig_pin <= 1'h0;
    else count_pin <= 1'h0;
    repeat (4) @(posedge clk);
    trig_pin <= 1'h1;
    count_pin <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
  // level of the other timer's overflow pulse
  task automatic other(input logic v);
    @(posedge clk);
    other_ovf <= v;
  endtask
endmodule

// *** verif/testbench.sv ***
`include "tmr2_defines.svh"
module testbench;
  import tmr2_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic [31:0] q;
  logic ack, cpin, tpin, oovf, rxc, txc, req, irq, seen_tx = 1'h0, arm_tx = 1'h0;
  int error_cnt = 0, checks_done = 0, cyc_cnt = 0;
  tmr2_top tmr2_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .count_input_pin(cpin), .trigger_input_pin(tpin),
    .other_timer_ovf(oovf), .uart_rx_clock(rxc), .uart_tx_clock(txc),
    .timer_req(req), .irq(irq));
  tmr2_pin_model tmr2_pin_model_inst (.clk(clk), .count_pin(cpin), .trig_pin(tpin),
    .other_ovf(oovf));
  always #4 clk = ~clk;
  // hang guard and a sticky view of the tx clock pulse
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    // cleared until armed, so earlier pass-through pulses cannot count
    if (!arm_tx) seen_tx <= 1'h0;
    else if (txc === 1'h1) seen_tx <= 1'h1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input tmr2_byte_t i, input tmr2_byte_t d,
    input logic [3:0] s = 4'h1);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= s;
    adr <= {i, 2'h0};
    dat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wr(input tmr2_byte_t i, input tmr2_byte_t d);
    bus(1'h1, i, d);
  endtask
  task automatic rd(input string n, input tmr2_byte_t i, input tmr2_byte_t e);
    bus(1'h0, i, 8'h00);
    chk(n, q, {24'h00_0000, e});
  endtask
  task automatic set_cnt(input tmr2_word_t v);
    wr(`TMR2_IDX_CNT_LO, v[7:0]);
    wr(`TMR2_IDX_CNT_HI, v[15:8]);
  endtask
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 10'h000;
    sel = 4'h0;
    dat = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd("ctrl", `TMR2_IDX_CTRL, 8'h00);
    rd("cnt_lo", `TMR2_IDX_CNT_LO, 8'h00);
    rd("cnt_hi", `TMR2_IDX_CNT_HI, 8'h00);
    rd("rcap_lo", `TMR2_IDX_RCAP_LO, 8'h00);
    rd("unmapped", 8'hc9, 8'h00);
    $display("test reset done");
    // timer mode rate: 23 run cycles give 11 or 12 steps
    wr(`TMR2_IDX_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    wr(`TMR2_IDX_CTRL, 8'h00);
    bus(1'h0, `TMR2_IDX_CNT_LO, 8'h00);
    chk("rate", 32'(q >= 11 && q <= 12), 32'h1);
    // overflow reloads, sets flag, raises request and masked irq
    wr(`TMR2_IDX_RCAP_LO, 8'h34);
    wr(`TMR2_IDX_RCAP_HI, 8'h12);
    set_cnt(16'hfffe);
    wr(`TMR2_IDX_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    rd("ovf", `TMR2_IDX_CTRL, 8'h84);
    chk("req", req, 1'h1);
    chk("irq_off", irq, 1'h0);
    wr(`TMR2_IDX_IRQ_MASK, 8'h01);
    chk("irq_on", irq, 1'h1);
    rd("stat", `TMR2_IDX_IRQ_STAT, 8'h01);
    wr(`TMR2_IDX_IRQ_STAT, 8'h01);
    chk("irq_clr", irq, 1'h0);
    wr(`TMR2_IDX_CTRL, 8'h00);
    chk("req_clr", req, 1'h0);
    rd("reload", `TMR2_IDX_CNT_HI, 8'h12);
    $display("test overflow done");
    // counter mode, then halted
    set_cnt(16'h0000);
    wr(`TMR2_IDX_CTRL, 8'h06);
    repeat (3) tmr2_pin_model_inst.fall(1'b0);
    wr(`TMR2_IDX_CTRL, 8'h02);
    tmr2_pin_model_inst.fall(1'b0);
    rd("count", `TMR2_IDX_CNT_LO, 8'h03);
    $display("test counter done");
    // capture on trigger fall, ignored while disabled
    set_cnt(16'h0055);
    wr(`TMR2_IDX_CTRL, 8'h09);
    tmr2_pin_model_inst.fall(1'b1);
    rd("cap", `TMR2_IDX_RCAP_LO, 8'h55);
    rd("trigf", `TMR2_IDX_CTRL, 8'h49);
    chk("req_t", req, 1'h1);
    wr(`TMR2_IDX_CTRL, 8'h01);
    set_cnt(16'h0066);
    tmr2_pin_model_inst.fall(1'b1);
    rd("nocap", `TMR2_IDX_RCAP_LO, 8'h55);
    // trigger reload, then blocked by a uart select
    wr(`TMR2_IDX_RCAP_LO, 8'h11);
    wr(`TMR2_IDX_RCAP_HI, 8'h22);
    wr(`TMR2_IDX_CTRL, 8'h08);
    tmr2_pin_model_inst.fall(1'b1);
    rd("trel", `TMR2_IDX_CNT_HI, 8'h22);
    set_cnt(16'h0077);
    wr(`TMR2_IDX_CTRL, 8'h18);
    tmr2_pin_model_inst.fall(1'b1);
    rd("norel", `TMR2_IDX_CNT_LO, 8'h77);
    rd("noflag", `TMR2_IDX_CTRL, 8'h18);
    // a write without byte lane 0 must leave the register alone
    bus(1'h1, `TMR2_IDX_RCAP_LO, 8'h99, 4'h0);
    rd("sel0", `TMR2_IDX_RCAP_LO, 8'h11);
    $display("test trigger done");
    // uart clock source per select bit
    for (int k = 0; k < 3; k++) begin
      wr(`TMR2_IDX_CTRL, 8'(k << 4));
      tmr2_pin_model_inst.other(1'h1);
      @(negedge clk);
      chk("tx_src", txc, 1'(k != 1));
      chk("rx_src", rxc, 1'(k != 2));
      tmr2_pin_model_inst.other(1'h0);
    end
    // uart mode: reload despite capture select, no flag
    set_cnt(16'hfffe);
    arm_tx <= 1'h1;
    wr(`TMR2_IDX_CTRL, 8'h35);
    repeat (20) @(posedge clk);
    rd("uovf", `TMR2_IDX_CTRL, 8'h35);
    chk("tx_pulse", seen_tx, 1'h1);
    wr(`TMR2_IDX_CTRL, 8'h00);
    rd("urel", `TMR2_IDX_CNT_HI, 8'h22);
    $display("test uart done");
    stop_test();
  end
endmodule
